// *** verilog/fwx_pkg.sv ***
// package: register map, field positions and timing for the fifo pair host
package fwx_pkg;
	localparam int unsigned DATA_W = 18;
	localparam int unsigned SLICE_W = 9;
	localparam int unsigned NDEV = 2;
	localparam int unsigned ADDR_W = 8;
	// =====================================================================
	// register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] WDATA_OFF = 8'h08;
	localparam logic [7:0] POP_OFF = 8'h0c;
	localparam logic [7:0] RDATA_OFF = 8'h10;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h18;
	// =====================================================================
	// field positions
	localparam int unsigned CTRL_MODE_BIT = 0;
	localparam int unsigned CTRL_RESET_BIT = 1;
	localparam int unsigned ST_EMPTY_BIT = 0;
	localparam int unsigned ST_FULL_BIT = 1;
	localparam int unsigned ST_BUSY_BIT = 2;
	localparam int unsigned ST_MODE_BIT = 3;
	localparam int unsigned ST_RVALID_BIT = 4;
	localparam int unsigned EV_RESET_DONE = 0;
	localparam int unsigned EV_WRITE_DONE = 1;
	localparam int unsigned EV_READ_DONE = 2;
	localparam int unsigned EV_OVERFLOW = 3;
	localparam int unsigned EV_UNDERFLOW = 4;
	localparam int unsigned EV_W = 5;
	// =====================================================================
	// reset values
	localparam logic CTRL_MODE_RST = 1'b0;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	// =====================================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned MRS_PULSE_NS = 10;
	localparam int unsigned MRS_CYCLES =
		(MRS_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// input sync depth plus one cycle of skew between the paired devices
	localparam int unsigned SETTLE_CYCLES = 4;
	localparam int unsigned CNT_W = 4;
	typedef enum logic [2:0] {
		FWX_ST_MRS = 3'b000,
		FWX_ST_IDLE = 3'b001,
		FWX_ST_WRITE = 3'b010,
		FWX_ST_READ = 3'b011,
		FWX_ST_SETTLE = 3'b100
	} fwx_state_t;
endpackage

// *** verilog/fwx_host.sv ***
// host controller for two paralleled deep fifos in width expansion
`timescale 1ns/1ps
// =====================================================================
module fwx_host (
	input wire logic mclk_in, // clock, also the fifos' clocks
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic [7:0] addr_in, // register byte address
	input wire logic [31:0] wdata_in, // register write data
	input wire logic wr_in, // register write strobe
	input wire logic rd_in, // register read strobe
	output logic [31:0] rdata_out, // read data, cycle after rd_in
	output logic irq_out, // level interrupt
	output logic master_reset_n_out, // master reset to both fifos
	output logic first_word_fallthrough_out, // mode strap at reset
	output logic write_enable_n_out, // common write enable
	output logic read_enable_n_out, // common read enable
	output logic [17:0] write_data_out, // both 9-bit write slices
	input wire logic [17:0] read_data_in, // both 9-bit read slices
	input wire logic [1:0] empty_indicator_n_in, // per-device empty
	input wire logic [1:0] full_indicator_n_in, // per-device full
	input wire logic [1:0] output_ready_n_in, // per-device out ready
	input wire logic [1:0] input_ready_n_in // per-device in ready
);
	localparam int unsigned PIN_W = 26;
	localparam logic [3:0] MRS_CNT =
		4'(fwx_pkg::MRS_CYCLES);
	localparam logic [3:0] SETTLE_CNT =
		4'(fwx_pkg::SETTLE_CYCLES);

	// =====================================================================
	// composite flags
	// a device that lags by a cycle holds the composite back, so the
	// pair never claims a word or a slot only one device has
	function automatic logic can_read(input logic first_word_fallthrough,
		input logic [1:0] ef_n, input logic [1:0] or_n);
		if (first_word_fallthrough) begin
			can_read = ~(|or_n);
		end else begin
			can_read = &ef_n;
		end
	endfunction

	function automatic logic can_write(input logic first_word_fallthrough,
		input logic [1:0] ff_n, input logic [1:0] ir_n);
		if (first_word_fallthrough) begin
			can_write = ~(|ir_n);
		end else begin
			can_write = &ff_n;
		end
	endfunction

	// =====================================================================
	// pin synchronisers: three stages, value taken when two and three agree
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] sync1_q;
	logic [PIN_W-1:0] sync2_q;
	logic [PIN_W-1:0] sync3_q;
	logic [PIN_W-1:0] pin_q;

	assign pin_raw = {read_data_in, empty_indicator_n_in,
		full_indicator_n_in, output_ready_n_in, input_ready_n_in};

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pin_q <= '1;
		end else begin
			pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));
		end
	end

	logic [17:0] rd_bus;
	logic [1:0] ef_n;
	logic [1:0] ff_n;
	logic [1:0] or_n;
	logic [1:0] ir_n;
	assign rd_bus = pin_q[25:8];
	assign ef_n = pin_q[7:6];
	assign ff_n = pin_q[5:4];
	assign or_n = pin_q[3:2];
	assign ir_n = pin_q[1:0];

	// =====================================================================
	// register decode
	logic wr_ctrl;
	logic wr_wdata;
	logic wr_pop;
	logic wr_istat;
	logic wr_imask;
	logic rd_rdata;
	assign wr_ctrl = wr_in && addr_in == fwx_pkg::CTRL_OFF;
	assign wr_wdata = wr_in && addr_in == fwx_pkg::WDATA_OFF;
	assign wr_pop = wr_in && addr_in == fwx_pkg::POP_OFF;
	assign wr_istat = wr_in && addr_in == fwx_pkg::IRQ_STAT_OFF;
	assign wr_imask = wr_in && addr_in == fwx_pkg::IRQ_MASK_OFF;
	assign rd_rdata = rd_in && addr_in == fwx_pkg::RDATA_OFF;

	logic mode_req_q;
	logic mode_q;
	logic reset_req;
	assign reset_req = wr_ctrl && wdata_in[fwx_pkg::CTRL_RESET_BIT];

	// mode written by software only reaches the pin from a control write that also sets the reset bit while idle
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			mode_req_q <= fwx_pkg::CTRL_MODE_RST;
		end else if (wr_ctrl) begin
			mode_req_q <= wdata_in[fwx_pkg::CTRL_MODE_BIT];
		end
	end

	// =====================================================================
	// sequencer
	fwx_pkg::fwx_state_t state_q;
	fwx_pkg::fwx_state_t state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic rdy_rd;
	logic rdy_wr;
	logic [17:0] pend_q;
	logic pend_wr_q;
	logic pend_rd_q;
	logic rd_pending_q;

	assign rdy_rd = can_read(mode_q, ef_n, or_n);
	assign rdy_wr = can_write(mode_q, ff_n, ir_n);

	logic idle_go_wr;
	logic idle_go_rd;
	assign idle_go_wr = state_q == fwx_pkg::FWX_ST_IDLE && pend_wr_q;
	assign idle_go_rd = state_q == fwx_pkg::FWX_ST_IDLE && !pend_wr_q &&
		pend_rd_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			fwx_pkg::FWX_ST_MRS: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					state_d = fwx_pkg::FWX_ST_SETTLE;
					cnt_d = SETTLE_CNT;
				end
			end
			fwx_pkg::FWX_ST_IDLE: begin
				if (reset_req) begin
					state_d = fwx_pkg::FWX_ST_MRS;
					cnt_d = MRS_CNT;
				end else if (idle_go_wr && rdy_wr) begin
					state_d = fwx_pkg::FWX_ST_WRITE;
				end else if (idle_go_rd && rdy_rd) begin
					state_d = fwx_pkg::FWX_ST_READ;
				end
			end
			fwx_pkg::FWX_ST_WRITE, fwx_pkg::FWX_ST_READ: begin
				state_d = fwx_pkg::FWX_ST_SETTLE;
				cnt_d = SETTLE_CNT;
			end
			fwx_pkg::FWX_ST_SETTLE: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					state_d = fwx_pkg::FWX_ST_IDLE;
				end
			end
			default: begin
				state_d = fwx_pkg::FWX_ST_IDLE;
				cnt_d = 4'h0;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			state_q <= fwx_pkg::FWX_ST_MRS;
			cnt_q <= MRS_CNT;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// strap is latched on entry to master reset and held afterwards
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			mode_q <= fwx_pkg::CTRL_MODE_RST;
		end else if (state_q == fwx_pkg::FWX_ST_IDLE && reset_req) begin
			mode_q <= wdata_in[fwx_pkg::CTRL_MODE_BIT];
		end
	end

	// =====================================================================
	// pending requests: one word of write data, one pop
	logic ovf_ev;
	logic unf_ev;
	assign ovf_ev = (idle_go_wr && !rdy_wr) || (wr_wdata && pend_wr_q);
	assign unf_ev = (idle_go_rd && !rdy_rd) || (wr_pop && pend_rd_q);

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pend_wr_q <= 1'b0;
			pend_q <= 18'h00000;
		end else if (wr_wdata && !pend_wr_q) begin
			pend_wr_q <= 1'b1;
			pend_q <= wdata_in[17:0];
		end else if (idle_go_wr) begin
			// refused writes are dropped and flagged, never retried
			pend_wr_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pend_rd_q <= 1'b0;
		end else if (wr_pop && !pend_rd_q) begin
			pend_rd_q <= 1'b1;
		end else if (idle_go_rd) begin
			pend_rd_q <= 1'b0;
		end
	end

	// =====================================================================
	// device pins, all registered and shared by both devices
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			master_reset_n_out <= 1'b0;
			first_word_fallthrough_out <= fwx_pkg::CTRL_MODE_RST;
			write_enable_n_out <= 1'b1;
			read_enable_n_out <= 1'b1;
			write_data_out <= 18'h00000;
		end else begin
			master_reset_n_out <= state_d != fwx_pkg::FWX_ST_MRS;
			first_word_fallthrough_out <= mode_q;
			write_enable_n_out <= state_d != fwx_pkg::FWX_ST_WRITE;
			read_enable_n_out <= state_d != fwx_pkg::FWX_ST_READ;
			if (state_d == fwx_pkg::FWX_ST_WRITE) begin
				write_data_out <= pend_q;
			end
		end
	end

	// =====================================================================
	// read capture
	// fall-through: the word is on the pins before the read strobe;
	// classic: it shows after the strobe and needs the whole sync delay,
	// which only ends in the first idle cycle after the settle
	logic [17:0] rword_q;
	logic rvalid_q;
	logic cap_now;
	assign cap_now = (mode_q && state_q == fwx_pkg::FWX_ST_READ) ||
		(!mode_q && rd_pending_q && state_q == fwx_pkg::FWX_ST_IDLE);

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rd_pending_q <= 1'b0;
		end else if (state_q == fwx_pkg::FWX_ST_READ) begin
			rd_pending_q <= 1'b1;
		end else if (state_q == fwx_pkg::FWX_ST_IDLE) begin
			rd_pending_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rword_q <= 18'h00000;
			rvalid_q <= 1'b0;
		end else if (cap_now) begin
			rword_q <= rd_bus;
			rvalid_q <= 1'b1;
		end else if (rd_rdata) begin
			rvalid_q <= 1'b0;
		end
	end

	// =====================================================================
	// interrupts: sticky events, write one to clear, set wins
	logic [4:0] ev;
	logic [4:0] istat_q;
	logic [4:0] imask_q;
	logic mrs_done;
	assign mrs_done = state_q == fwx_pkg::FWX_ST_MRS && cnt_q == 4'h1;
	assign ev = {unf_ev, ovf_ev, cap_now,
		state_q == fwx_pkg::FWX_ST_WRITE, mrs_done};

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			istat_q <= 5'h00;
		end else if (wr_istat) begin
			istat_q <= (istat_q & ~wdata_in[4:0]) | ev;
		end else begin
			istat_q <= istat_q | ev;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			imask_q <= fwx_pkg::IRQ_MASK_RST;
		end else if (wr_imask) begin
			imask_q <= wdata_in[4:0];
		end
	end

	assign irq_out = |(istat_q & imask_q);

	// =====================================================================
	// register read, one cycle after the strobe; unmapped reads zero
	logic [31:0] rsel;
	logic busy;
	assign busy = state_q != fwx_pkg::FWX_ST_IDLE || pend_wr_q || pend_rd_q;

	always_comb begin
		rsel = 32'h00000000;
		case (addr_in)
			fwx_pkg::CTRL_OFF: begin
				rsel[fwx_pkg::CTRL_MODE_BIT] = mode_req_q;
			end
			fwx_pkg::STATUS_OFF: begin
				rsel[fwx_pkg::ST_EMPTY_BIT] = !rdy_rd;
				rsel[fwx_pkg::ST_FULL_BIT] = !rdy_wr;
				rsel[fwx_pkg::ST_BUSY_BIT] = busy;
				rsel[fwx_pkg::ST_MODE_BIT] = mode_q;
				rsel[fwx_pkg::ST_RVALID_BIT] = rvalid_q;
			end
			fwx_pkg::RDATA_OFF: begin
				rsel[17:0] = rword_q;
			end
			fwx_pkg::IRQ_STAT_OFF: begin
				rsel[4:0] = istat_q;
			end
			fwx_pkg::IRQ_MASK_OFF: begin
				rsel[4:0] = imask_q;
			end
			default: begin
				rsel = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rdata_out <= 32'h00000000;
		end else begin
			rdata_out <= rd_in ? rsel : 32'h00000000;
		end
	end
endmodule

// *** test/fwx_host_asserts.sv ***
// checker for the fifo pair host ports
`timescale 1ns/1ps
module fwx_host_asserts (
	input wire logic mclk_in, // clock
	input wire logic rst_n_in, // reset
	input wire logic [7:0] addr_in, // bus
	input wire logic [31:0] wdata_in, // bus
	input wire logic wr_in, // bus
	input wire logic rd_in, // bus
	input wire logic [31:0] rdata_out, // bus
	input wire logic irq_out, // irq
	input wire logic master_reset_n_out, // fifo
	input wire logic first_word_fallthrough_out, // fifo
	input wire logic write_enable_n_out, // fifo
	input wire logic read_enable_n_out, // fifo
	input wire logic [17:0] write_data_out, // fifo
	input wire logic [17:0] read_data_in, // fifo
	input wire logic [1:0] empty_indicator_n_in, // fifo
	input wire logic [1:0] full_indicator_n_in, // fifo
	input wire logic [1:0] output_ready_n_in, // fifo
	input wire logic [1:0] input_ready_n_in // fifo
);
	default clocking dc @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	wire we = !write_enable_n_out;
	wire re = !read_enable_n_out;
	wire mrs = !master_reset_n_out;
	wire fw = first_word_fallthrough_out;
	// ========
	// device strobes
	a_we_pulse: assert property (
		we |=> !we) else $error("long write enable");
	a_one_strobe: assert property (
		!(we && re)) else $error("both enables low");
	// settle gap lets one cycle of device flag skew pass
	a_strobe_gap: assert property (
		$rose(we) || $rose(re) |=> (!we && !re)[*4])
		else $error("strobes too close");
	a_wr_classic: assert property (
		$rose(we) && !fw |-> &$past(full_indicator_n_in))
		else $error("write while full");
	a_rd_classic: assert property (
		$rose(re) && !fw |-> &$past(empty_indicator_n_in))
		else $error("read while empty");
	a_wr_first_word_fallthrough: assert property (
		$rose(we) && fw |-> ~|$past(input_ready_n_in))
		else $error("write while not ready");
	a_rd_first_word_fallthrough: assert property (
		$rose(re) && fw |-> ~|$past(output_ready_n_in))
		else $error("read while not ready");
	// ========
	// data and master reset
	a_data_hold: assert property (
		!we |-> $stable(write_data_out)) else $error("data moved");
	a_rdata_idle: assert property (
		!$past(rd_in) |-> rdata_out == 32'h0) else $error("stray rdata");
	a_mrs_width: assert property (
		$rose(mrs) |-> mrs[*2]) else $error("short master reset");
	a_quiet_mrs: assert property (
		mrs |-> !we && !re) else $error("strobe in master reset");
	a_mode_at_mrs: assert property (
		$fell(mrs) |-> $stable(fw)) else $error("mode moved");
	c_fw_write: cover property ($rose(we) && fw);
	c_classic_read: cover property ($rose(re) && !fw);
	c_irq: cover property ($rose(irq_out));
endmodule
bind fwx_host fwx_host_asserts i_chk (
	.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
	.irq_out, .master_reset_n_out, .first_word_fallthrough_out,
	.write_enable_n_out, .read_enable_n_out, .write_data_out,
	.read_data_in, .empty_indicator_n_in, .full_indicator_n_in,
	.output_ready_n_in, .input_ready_n_in
);

// *** test/fwx_fifo_pair_model.sv ***
// two paralleled fifo devices on one write, read and transfer clock
`timescale 1ns/1ps
module fwx_fifo_pair_model #(
	parameter int DEPTH = 4 // shared depth of both devices
) (
	input wire logic mclk_in, // clock
	input wire logic master_reset_n_in, // master reset
	input wire logic first_word_fallthrough_in, // mode
	input wire logic write_enable_n_in, // write
	input wire logic read_enable_n_in, // read
	input wire logic [17:0] write_data_in, // slices
	output logic [17:0] read_data_out, // slices
	output logic [1:0] empty_indicator_n_out, // flags
	output logic [1:0] full_indicator_n_out, // flags
	output logic [1:0] output_ready_n_out, // flags
	output logic [1:0] input_ready_n_out // flags
);
	logic [17:0] mem_q [DEPTH];
	int cnt_q;
	int lag_q;
	int wp_q;
	int rp_q;
	logic fw_q;
	logic [17:0] out_q;
	wire wr_ok = !write_enable_n_in && cnt_q < DEPTH;
	wire rd_ok = !read_enable_n_in && cnt_q > 0;
	// ========
	// storage
	always_ff @(posedge mclk_in) begin
		lag_q <= cnt_q;
		if (!master_reset_n_in) begin
			fw_q <= first_word_fallthrough_in;
			cnt_q <= 0;
			wp_q <= 0;
			rp_q <= 0;
		end else begin
			if (wr_ok) begin
				mem_q[wp_q] <= write_data_in;
				wp_q <= (wp_q + 1) % DEPTH;
			end
			if (rd_ok) begin
				out_q <= mem_q[rp_q];
				rp_q <= (rp_q + 1) % DEPTH;
			end
			cnt_q <= cnt_q + int'(wr_ok) - int'(rd_ok);
		end
	end
	// ========
	// flags: device 1 lags a cycle, the worst skew allowed
	assign empty_indicator_n_out = {lag_q != 0, cnt_q != 0};
	assign full_indicator_n_out = {lag_q != DEPTH, cnt_q != DEPTH};
	assign output_ready_n_out = {lag_q == 0, cnt_q == 0};
	assign input_ready_n_out = {lag_q == DEPTH, cnt_q == DEPTH};
	// an empty fall-through bus shows the inverse, never a stale word
	assign read_data_out = !fw_q ? out_q :
		cnt_q != 0 ? mem_q[rp_q] : ~out_q;
endmodule

// *** test/tb_fwx_host.sv ***
// self-checking bench for the fifo pair host
`timescale 1ns/1ps
module tb_fwx_host;
	localparam int DEPTH = 4;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic irq_out, mrs_n, fw, we_n, re_n;
	logic [17:0] wd, rdd;
	logic [1:0] e_n, f_n, o_n, i_n;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [17:0] words [$];
	fwx_host i_dut (
		.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .irq_out, .master_reset_n_out(mrs_n),
		.first_word_fallthrough_out(fw), .write_enable_n_out(we_n),
		.read_enable_n_out(re_n), .write_data_out(wd),
		.read_data_in(rdd), .empty_indicator_n_in(e_n),
		.full_indicator_n_in(f_n), .output_ready_n_in(o_n),
		.input_ready_n_in(i_n)
	);
	fwx_fifo_pair_model #(.DEPTH(DEPTH)) i_fifo (
		.mclk_in, .master_reset_n_in(mrs_n),
		.first_word_fallthrough_in(fw), .write_enable_n_in(we_n),
		.read_enable_n_in(re_n), .write_data_in(wd),
		.read_data_out(rdd), .empty_indicator_n_out(e_n),
		.full_indicator_n_out(f_n), .output_ready_n_out(o_n),
		.input_ready_n_out(i_n)
	);
	initial forever #4 mclk_in = ~mclk_in;
	// ========
	// bus tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	// n above one holds the strobe to send back-to-back requests
	task automatic wr(input logic [7:0] a, input logic [31:0] d, int n);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		repeat (n) @(posedge mclk_in);
		wr_in <= 1'b0;
		repeat (12) @(posedge mclk_in);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, e);
	endtask
	function automatic logic [31:0] stat(input logic m, input int n);
		return {27'h0, 1'b0, m, 1'b0, n == DEPTH, n == 0};
	endfunction
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ========
	// fill past full, drain past empty, in one mode
	task automatic run(input logic m);
		logic [17:0] w;
		words.delete();
		wr(8'h00, {30'h0, 1'b1, m}, 1);
		wr(8'h14, 32'h1f, 1);
		rd(8'h04, stat(m, 0));
		for (int i = 0; i < DEPTH; i++) begin
			w = 18'($urandom);
			words.push_back(w);
			wr(8'h08, {14'h0, w}, 1);
			rd(8'h04, stat(m, i + 1));
		end
		wr(8'h08, 32'h155, 1);
		rd(8'h14, 32'h0a);
		wr(8'h14, 32'h1f, 1);
		for (int i = 0; i < DEPTH; i++) begin
			wr(8'h0c, 32'h0, 1);
			rd(8'h10, {14'h0, words.pop_front()});
		end
		w = 18'($urandom);
		wr(8'h08, {14'h0, w}, 2);
		wr(8'h0c, 32'h0, 1);
		rd(8'h10, {14'h0, w});
		wr(8'h0c, 32'h0, 1);
		rd(8'h14, 32'h1e);
		rd(8'h04, stat(m, 0));
		$display("test mode %0d done", m);
	endtask
	initial begin
		void'($urandom(32'h283969eb));
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (12) @(posedge mclk_in);
		rd(8'h00, 32'h0);
		rd(8'h18, 32'h0);
		rd(8'h1c, 32'h0);
		rd(8'h14, 32'h1);
		rd(8'h04, stat(1'b0, 0));
		$display("test reset done");
		wr(8'h14, 32'h1f, 1);
		wr(8'h18, 32'h02, 1);
		wr(8'h08, 32'h123, 1);
		chk({31'h0, irq_out}, 32'h1);
		wr(8'h14, 32'h02, 1);
		chk({31'h0, irq_out}, 32'h0);
		wr(8'h18, 32'h00, 1);
		wr(8'h08, 32'h0ab, 1);
		chk({31'h0, irq_out}, 32'h0);
		rd(8'h14, 32'h02);
		$display("test irq done");
		run(1'b0);
		run(1'b1);
		end_sim;
	end
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			end_sim;
		end
	end
endmodule
